// [drps_pkg.sv]
package drps_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_KEY    = 8'h04;
	localparam logic [7:0] ADR_GF_THR = 8'h08;
	localparam logic [7:0] ADR_OL_SET = 8'h0C;
	localparam logic [7:0] ADR_THERM  = 8'h10;
	localparam logic [7:0] ADR_STATUS = 8'h14;
	localparam logic [7:0] ADR_COOL   = 8'h18;
	// ctrl fields
	localparam int C_RESTART = 0;
	localparam int C_CFG_LO  = 1;
	localparam int C_FOUR_SP = 4;
	localparam int C_SEL_EN  = 5;
	localparam logic [2:0] CFG_BASIC  = 3'h0;
	localparam logic [2:0] CFG_DIG_CP = 3'h1;
	localparam logic [2:0] CFG_AN_CP  = 3'h2;
	localparam logic [2:0] CFG_REDUND = 3'h3;
	// key register bits, each a one-shot press
	localparam int K_HALT    = 0;
	localparam int K_MANUAL  = 1;
	localparam int K_RUN     = 2;
	localparam int K_STOP    = 3;
	localparam int K_HOME    = 4;
	localparam int K_UP      = 5;
	localparam int K_DOWN    = 6;
	localparam int K_ENTER   = 7;
	localparam int K_RESTORE = 8;
	localparam int K_AUTO    = 9;
	localparam int K_GF_CLR  = 10;
	// contact / sensor-fail input indices
	localparam int I_RA = 0;
	localparam int I_RB = 1;
	localparam int I_SA = 2;
	localparam int I_SB = 3;
	localparam int I_PF = 4;
	localparam int N_IN = 5;
	// timing
	localparam int CLK_KHZ      = 125000;
	localparam int RAMP1_MS     = 1000;
	localparam int RAMP2_MS     = 8000;
	localparam logic [6:0] F_MIN = 7'h1E;
	localparam logic [6:0] F_MAX = 7'h3C;
	localparam int DEBOUNCE_US  = 10000;
	localparam int DB_CYC       = (DEBOUNCE_US * CLK_KHZ) / 1000;
	localparam int TICK_MS      = 100;
	localparam int TICK_CYC     = TICK_MS * CLK_KHZ;
	localparam int TICKS_PER_S  = 1000 / TICK_MS;
	// overload: class 10, 600 % trips in 10 s; net heat at 6x is 35 set^2
	localparam int OL_CLASS_S   = 10;
	localparam int OL_NET_6X    = 35;
	localparam int OL_MULT      = OL_CLASS_S * TICKS_PER_S * OL_NET_6X;
	localparam int COOL_S       = 300;
	localparam logic [15:0] COOL_TICKS = 16'(COOL_S * TICKS_PER_S);
	localparam logic [8:0] GF_FULL = 9'h0FF;
	localparam logic [2:0] WIZ_LAST = 3'h4;
	typedef enum logic [3:0] {
		M_INIT = 4'b0001,
		M_OFF  = 4'b0010,
		M_AUTO = 4'b0100,
		M_MAN  = 4'b1000
	} drps_mode_t;
endpackage

// [drps_top.sv]
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module drps_top
	import drps_pkg::*;
#(
	parameter int RAMP1_CYC = (RAMP1_MS * CLK_KHZ) / int'(F_MIN),
	parameter int RAMP2_CYC = (RAMP2_MS * CLK_KHZ) / int'(F_MAX - F_MIN),
	parameter int DB_CYCLES = DB_CYC,
	parameter int TICK_CYCLES = TICK_CYC
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	input  wire logic        run_contact_a,
	input  wire logic        run_contact_b,
	input  wire logic        select_contact_a,
	input  wire logic        select_contact_b,
	input  wire logic        primary_loop_fail,
	input  wire logic        restart_strap,
	input  wire logic        params_blank,
	input  wire logic [7:0]  motor_current,
	input  wire logic [7:0]  earth_leak_level,
	output logic             motor_run,
	output logic             gate_enable,
	output logic [6:0]       out_freq_hz,
	output logic [1:0]       setpoint_sel,
	output logic             backup_loop_sel,
	output logic             ground_fault,
	output logic             overload_fault,
	output logic             wizard_active
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		drps_mode_t        mode;
		logic              man_run;
		logic [N_IN-1:0]   s1;
		logic [N_IN-1:0]   s2;
		logic [N_IN-1:0]   db;
		logic [N_IN-1:0][23:0] dbc;
		logic              restart;
		logic [2:0]        cfg;
		logic              four_sp;
		logic              sel_en;
		logic [7:0]        gf_thr;
		logic [7:0]        ol_set;
		logic [31:0]       therm;
		logic [15:0]       cool;
		logic              ol_flt;
		logic              gf_flt;
		logic              wiz;
		logic [2:0]        wsel;
		logic [23:0]       tick;
		logic [25:0]       rcnt;
		logic [6:0]        freq;
		logic              run;
		logic              gate;
		logic [1:0]        sp;
		logic              bk;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
	} drps_state_t;

	drps_state_t st_q;
	drps_state_t st_d;

	logic [N_IN-1:0] pins;
	logic            wr;
	logic [15:0]     keys;
	logic            perm;
	logic            tick;
	logic [15:0]     set_sq;
	logic [15:0]     cur_sq;
	logic [31:0]     ol_lim;
	logic [32:0]     heat;
	logic [31:0]     status;

	assign pins = {primary_loop_fail, select_contact_b, select_contact_a,
		run_contact_b, run_contact_a};
	assign wr   = psel && penable && st_q.pready && pwrite;
	assign keys = (wr && paddr == ADR_KEY) ? pwdata[15:0] : 16'h0000;
	assign tick = st_q.tick == 24'(TICK_CYCLES - 1);
	assign set_sq = 16'(st_q.ol_set) * 16'(st_q.ol_set);
	assign cur_sq = 16'(motor_current) * 16'(motor_current);
	// class 10 limit scales with the square of the overload setting
	assign ol_lim = 32'(set_sq) * 32'(OL_MULT);
	assign status = {9'h000, st_q.wsel, st_q.wiz, st_q.freq, st_q.sp,
		st_q.bk, st_q.gf_flt, st_q.ol_flt, st_q.gate, st_q.run, st_q.man_run,
		st_q.mode};

	// run permission from debounced contacts, per configuration
	always_comb
	begin
		if (st_q.cfg == CFG_REDUND && !st_q.four_sp)
			perm = st_q.db[I_RA];
		else
			perm = st_q.db[I_RA] && st_q.db[I_RB];
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		st_d = st_q;
		// two-stage synchroniser, then debounce
		st_d.s1 = pins;
		st_d.s2 = st_q.s1;
		for (int i = 0; i < N_IN; i++)
		begin
			if (st_q.s2[i] == st_q.db[i])
				st_d.dbc[i] = 24'h000000;
			else if (st_q.dbc[i] == 24'(DB_CYCLES - 1))
			begin
				st_d.db[i]  = st_q.s2[i];
				st_d.dbc[i] = 24'h000000;
			end
			else
				st_d.dbc[i] = st_q.dbc[i] + 24'h000001;
		end

		// apb register writes
		if (wr)
		begin
			case (paddr)
				ADR_CTRL:
				begin
					st_d.restart = pwdata[C_RESTART];
					st_d.cfg     = pwdata[C_CFG_LO +: 3];
					st_d.four_sp = pwdata[C_FOUR_SP];
					st_d.sel_en  = pwdata[C_SEL_EN];
				end
				ADR_GF_THR: st_d.gf_thr = pwdata[7:0];
				ADR_OL_SET: st_d.ol_set = pwdata[7:0];
				default: st_d.restart = st_q.restart;
			endcase
		end

		// mode and keys; halt outranks the manual, auto and run keys
		case (st_q.mode)
			M_INIT:
			begin
				st_d.restart = restart_strap;
				st_d.wiz     = params_blank;
				st_d.mode    = restart_strap ? M_AUTO : M_OFF;
			end
			M_OFF, M_AUTO, M_MAN:
			begin
				if (keys[K_HALT])
					st_d.mode = M_OFF;
				else if (keys[K_MANUAL])
					st_d.mode = M_MAN;
				else if (keys[K_AUTO])
					st_d.mode = M_AUTO;
				// a trip in AUTO without restart permission drops to OFF
				else if (st_q.ol_flt && !st_q.restart && st_q.mode == M_AUTO)
					st_d.mode = M_OFF;
			end
			default: st_d.mode = M_OFF;
		endcase
		if (st_d.mode != M_MAN || keys[K_STOP])
			st_d.man_run = 1'b0;
		else if (keys[K_RUN])
			st_d.man_run = 1'b1;

		// setup wizard: scheme 0..4, enter accepts, home skips
		if (keys[K_RESTORE])
		begin
			st_d.wiz     = 1'b1;
			st_d.wsel    = 3'h0;
			st_d.restart = 1'b0;
			st_d.cfg     = CFG_BASIC;
		end
		else if (st_q.wiz)
		begin
			if (keys[K_HOME] || keys[K_ENTER])
				st_d.wiz = 1'b0;
			if (keys[K_UP] && st_q.wsel != WIZ_LAST)
				st_d.wsel = st_q.wsel + 3'h1;
			else if (keys[K_DOWN] && st_q.wsel != 3'h0)
				st_d.wsel = st_q.wsel - 3'h1;
		end

		// ground fault: a lower threshold raises the trip level
		if ({1'b0, earth_leak_level} + {1'b0, st_q.gf_thr} > GF_FULL)
			st_d.gf_flt = 1'b1;
		else if (keys[K_GF_CLR])
			st_d.gf_flt = 1'b0;

		// thermal model on a slow tick
		st_d.tick = tick ? 24'h000000 : st_q.tick + 24'h000001;
		heat = {1'b0, st_q.therm} + (st_q.run ? 33'(cur_sq) : 33'h000000000);
		if (tick)
		begin
			// heating while running, cooling always
			st_d.therm = (heat > 33'(set_sq)) ? 32'(heat - 33'(set_sq))
				: 32'h00000000;
			if (st_q.cool != 16'h0000)
				st_d.cool = st_q.cool - 16'h0001;
		end
		// restore of a retained estimate before restart
		if (wr && paddr == ADR_THERM)
			st_d.therm = pwdata;
		if (st_q.therm >= ol_lim && st_q.run && !st_q.ol_flt)
		begin
			st_d.ol_flt = 1'b1;
			st_d.cool   = COOL_TICKS;
		end
		else if (st_q.ol_flt && st_q.cool == 16'h0000 && st_q.therm < ol_lim)
			st_d.ol_flt = 1'b0;

		// run decision and gate inhibit
		st_d.run = !st_q.ol_flt && ((st_q.mode == M_AUTO && perm)
			|| (st_q.mode == M_MAN && st_q.man_run));
		st_d.gate = st_d.run && !st_d.gf_flt;

		// start ramp; stop coasts, so frequency drops at once
		if (!st_q.run)
		begin
			st_d.freq = 7'h00;
			st_d.rcnt = 26'h0000000;
		end
		else if (st_q.freq != F_MAX)
		begin
			if (st_q.rcnt == 26'((st_q.freq < F_MIN ? RAMP1_CYC : RAMP2_CYC) - 1))
			begin
				st_d.freq = st_q.freq + 7'h01;
				st_d.rcnt = 26'h0000000;
			end
			else
				st_d.rcnt = st_q.rcnt + 26'h0000001;
		end

		// setpoint and sensor selection
		if (st_q.cfg == CFG_REDUND && !st_q.four_sp)
			st_d.sp = {1'b0, st_q.db[I_RB]};
		else if ((st_q.cfg == CFG_REDUND && st_q.four_sp)
			|| (st_q.cfg == CFG_BASIC && st_q.sel_en))
			st_d.sp = {st_q.db[I_SB], st_q.db[I_SA]};
		else
			st_d.sp = 2'h0;
		st_d.bk = st_q.cfg == CFG_REDUND && st_q.db[I_PF];

		// apb answer: one wait-free access phase
		st_d.pready  = psel && !penable;
		st_d.pslverr = 1'b0;
		st_d.prdata  = 32'h00000000;
		if (psel && !penable)
		begin
			case (paddr)
				ADR_CTRL: st_d.prdata = 32'({st_q.sel_en, st_q.four_sp,
					st_q.cfg, st_q.restart});
				ADR_KEY: st_d.prdata = 32'h00000000;
				ADR_GF_THR: st_d.prdata = 32'(st_q.gf_thr);
				ADR_OL_SET: st_d.prdata = 32'(st_q.ol_set);
				ADR_THERM: st_d.prdata = st_q.therm;
				ADR_STATUS: st_d.prdata = status;
				ADR_COOL: st_d.prdata = 32'(st_q.cool);
				default: st_d.pslverr = 1'b1;
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q         <= '0;
			st_q.mode    <= M_INIT;
			st_q.four_sp <= 1'b1;
			st_q.ol_set  <= 8'h80;
			st_q.gf_thr  <= 8'h80;
		end
		else
			st_q <= st_d;
	end

	assign pready          = st_q.pready;
	assign pslverr         = st_q.pslverr;
	assign prdata          = st_q.prdata;
	assign motor_run       = st_q.run;
	assign gate_enable     = st_q.gate;
	assign out_freq_hz     = st_q.freq;
	assign setpoint_sel    = st_q.sp;
	assign backup_loop_sel = st_q.bk;
	assign ground_fault    = st_q.gf_flt;
	assign overload_fault  = st_q.ol_flt;
	assign wizard_active   = st_q.wiz;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	init_off_a: assert property ((st_q.mode == M_INIT && !restart_strap)
		|=> st_q.mode == M_OFF) else $error("power-up did not enter off");
	init_auto_a: assert property ((st_q.mode == M_INIT && restart_strap)
		|=> st_q.mode == M_AUTO && st_q.restart) else $error("no auto power-up");
	halt_off_a: assert property (keys[K_HALT] && st_q.mode != M_INIT
		|=> st_q.mode == M_OFF ##1 !st_q.run) else $error("halt ignored");
	contact_stop_a: assert property ((st_q.mode == M_AUTO && !st_q.db[I_RA])
		|=> !st_q.run) else $error("ran with run contact open");
	man_run_a: assert property ((st_q.mode == M_MAN && st_q.man_run
		&& !st_q.ol_flt) |=> st_q.run) else $error("manual run refused");
	ramp_cap_a: assert property ($rose(st_q.run) |=> st_q.freq == 7'h00
		##1 st_q.freq <= F_MAX) else $error("ramp start wrong");
	gf_gate_a: assert property (st_q.gf_flt |-> !st_q.gate)
		else $error("gating while ground fault");
	ol_cool_a: assert property ($rose(st_q.ol_flt) |-> st_q.cool == COOL_TICKS
		##1 !st_q.run) else $error("cooling timer not loaded");
	sp_sel_a: assert property ((st_q.cfg == CFG_REDUND && st_q.four_sp)
		|=> st_q.sp == $past({st_q.db[I_SB], st_q.db[I_SA]}))
		else $error("setpoint select wrong");
	two_sp_a: assert property ((st_q.cfg == CFG_REDUND && !st_q.four_sp)
		|=> st_q.sp == {1'b0, $past(st_q.db[I_RB])}) else $error("two-sp wrong");
	backup_a: assert property ((st_q.cfg == CFG_REDUND && st_q.db[I_PF])
		|=> st_q.bk) else $error("no failover to backup");
	wiz_skip_a: assert property ((st_q.wiz && keys[K_HOME] && !keys[K_RESTORE])
		|=> !st_q.wiz) else $error("home did not skip wizard");
	ramp_step_a: assert property (st_q.run |=> st_q.freq == $past(st_q.freq)
		|| st_q.freq == $past(st_q.freq) + 7'h01) else $error("ramp step too large");
	freq_idle_a: assert property (!st_q.run |=> st_q.freq == 7'h00)
		else $error("frequency without run");
	gf_trip_a: assert property ((9'(earth_leak_level) + 9'(st_q.gf_thr) > GF_FULL)
		|=> st_q.gf_flt && !st_q.gate) else $error("earth leak not tripped");
	ol_trip_a: assert property ((st_q.therm >= ol_lim && st_q.run) |=> st_q.ol_flt)
		else $error("overload not tripped");
	restore_a: assert property (keys[K_RESTORE] |=> st_q.wiz && !st_q.restart
		&& st_q.cfg == CFG_BASIC) else $error("restore incomplete");
	ol_drop_a: assert property ((st_q.ol_flt && !st_q.restart && st_q.mode == M_AUTO
		&& !keys[K_MANUAL] && !keys[K_AUTO]) |=> st_q.mode == M_OFF)
		else $error("trip kept auto without restart");

	run_auto_c: cover property (st_q.mode == M_AUTO ##1 st_q.run [*3]);
	ol_trip_c: cover property ($rose(st_q.ol_flt));
	failover_c: cover property ($rose(st_q.bk) && st_q.run);
	ramp_top_c: cover property (st_q.freq == F_MAX);
	wiz_done_c: cover property (st_q.wiz ##1 !st_q.wiz);
endmodule

// [drps_field.sv]
`timescale 1ns/100ps
// ----------------------------------------
// field side: contacts, loop sensor, meters
// ----------------------------------------
module drps_field (
	input  wire logic       pclk,
	input  wire logic [3:0] want,
	input  wire logic       pf_want,
	input  wire logic [7:0] cur_want,
	input  wire logic [7:0] leak_want,
	output logic [3:0]      pins,
	output logic            pf,
	output logic [7:0]      cur,
	output logic [7:0]      leak
);
	logic [3:0] last_q;
	logic [2:0] bounce_q;
	initial
	begin
		last_q = 4'h0;
		bounce_q = 3'h0;
		pins = 4'h0;
		pf = 1'b0;
		cur = 8'h00;
		leak = 8'h00;
	end
	// a moved contact chatters with one-cycle glitches on every pin before it settles
	always @(posedge pclk)
	begin
		last_q <= want;
		bounce_q <= (want != last_q) ? 3'h4 : (bounce_q != 3'h0) ? bounce_q - 3'h1 : 3'h0;
		pins <= bounce_q[0] ? ~want : want;
		pf <= pf_want;
		cur <= cur_want;
		leak <= leak_want;
	end
endmodule

// [drps_top_tb.sv]
`timescale 1ns/100ps
module drps_top_tb;
	import drps_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr, cur_w, leak_w, cur, leak, thr, lk;
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  want, pins;
	logic        pf_w, pf, strap, blank, four, motor_run, gate_enable;
	logic        backup_loop_sel, ground_fault, overload_fault, wizard_active;
	logic [6:0]  out_freq_hz;
	logic [1:0]  setpoint_sel, cfg;
	int          fails, tests_run, cyc, ch, t, seed;

	drps_top #(.RAMP1_CYC(4), .RAMP2_CYC(8), .DB_CYCLES(3), .TICK_CYCLES(16)) drps_top_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.run_contact_a(pins[0]), .run_contact_b(pins[1]), .select_contact_a(pins[2]),
		.select_contact_b(pins[3]), .primary_loop_fail(pf), .restart_strap(strap),
		.params_blank(blank), .motor_current(cur), .earth_leak_level(leak),
		.motor_run(motor_run), .gate_enable(gate_enable), .out_freq_hz(out_freq_hz),
		.setpoint_sel(setpoint_sel), .backup_loop_sel(backup_loop_sel),
		.ground_fault(ground_fault), .overload_fault(overload_fault),
		.wizard_active(wizard_active));
	drps_field drps_field_i (.pclk(pclk), .want(want), .pf_want(pf_w), .cur_want(cur_w),
		.leak_want(leak_w), .pins(pins), .pf(pf), .cur(cur), .leak(leak));

	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// an idle edge first, so a strobe is never lowered and raised in one time step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the bench timeout ends this wait
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic key(input int b);
		apb(1'b1, ADR_KEY, 32'h1 << b);
	endtask
	task automatic waitv(input string nm, ref logic s, input logic v, input int lim);
		int n;
		n = 0;
		while (s !== v && n < lim)
		begin
			@(posedge pclk);
			n++;
		end
		chk(nm, s, v);
	endtask
	// counts motor_run changes while the contacts settle
	task automatic settle();
		logic p;
		ch = 0;
		p = motor_run;
		repeat (16)
		begin
			@(posedge pclk);
			if (motor_run !== p)
				ch++;
			p = motor_run;
		end
	endtask

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			summarize();
		end
	end

	initial
	begin
		{presetn, psel, penable, pwrite, pf_w, strap, four} = 7'h00;
		{paddr, pwdata, cur_w, leak_w, want, cfg, blank} = 'h1;
		{cur_w, leak_w, want} = 'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		seed = $urandom(76);
		apb(1'b0, ADR_STATUS, 32'h0);
		chk("mode", q[3:0], M_OFF);
		chk("wizard", wizard_active, 1'b1);
		apb(1'b0, ADR_CTRL, 32'h0);
		chk("ctrl", q, 32'h10);
		apb(1'b0, ADR_GF_THR, 32'h0);
		chk("gf_thr", q, 32'h80);
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped", e, 1'b1);
		key(K_HOME);
		waitv("wizard", wizard_active, 1'b0, 4);
		key(K_AUTO);
		// ----------------------------------------
		// schemes, run permission, setpoints
		// ----------------------------------------
		for (int k = 0; k < 24; k++)
		begin
			cfg = 2'(k % 4);
			four = 1'((k / 4) % 2);
			apb(1'b1, ADR_CTRL, {26'h0, 1'b1, four, 1'b0, cfg, 1'b0});
			settle();
			want <= 4'($urandom);
			pf_w <= 1'($urandom);
			settle();
			chk("bounce", ch <= 1, 1'b1);
			chk("run", motor_run, (cfg == 2'h3 && !four) ? want[0] : &want[1:0]);
			if (cfg == 2'h3)
			begin
				chk("backup", backup_loop_sel, pf_w);
				chk("setpt", setpoint_sel, four ? want[3:2] : {1'b0, want[1]});
			end
			else
			begin
				chk("no_backup", backup_loop_sel, 1'b0);
				chk("setpt", setpoint_sel, (cfg == 2'h0) ? want[3:2] : 2'h0);
			end
		end
		// ----------------------------------------
		// start ramp, halt, open contact
		// ----------------------------------------
		apb(1'b1, ADR_CTRL, 32'h10);
		want <= 4'h0;
		settle();
		want <= 4'h3;
		waitv("run", motor_run, 1'b1, 40);
		t = 0;
		while (out_freq_hz !== 7'h1E && t < 400)
		begin
			@(posedge pclk);
			t++;
		end
		chk("ramp1", t >= 116 && t <= 124, 1'b1);
		t = 0;
		while (out_freq_hz !== 7'h3C && t < 400)
		begin
			@(posedge pclk);
			t++;
		end
		chk("ramp2", t >= 236 && t <= 244, 1'b1);
		repeat (20) @(posedge pclk);
		chk("fmax", out_freq_hz, 7'h3C);
		key(K_HALT);
		waitv("halt", motor_run, 1'b0, 10);
		apb(1'b0, ADR_STATUS, 32'h0);
		chk("mode", q[3:0], M_OFF);
		key(K_AUTO);
		waitv("run", motor_run, 1'b1, 10);
		want <= 4'h2;
		waitv("open", motor_run, 1'b0, 20);
		// ----------------------------------------
		// manual run, earth leak
		// ----------------------------------------
		key(K_MANUAL);
		key(K_RUN);
		waitv("man", motor_run, 1'b1, 10);
		key(K_STOP);
		waitv("stop", motor_run, 1'b0, 10);
		key(K_RUN);
		for (int i = 0; i < 8; i++)
		begin
			thr = (i < 2) ? 8'h10 : 8'($urandom);
			lk = (i < 2) ? 8'hF0 - 8'(i) : 8'($urandom);
			apb(1'b1, ADR_GF_THR, {24'h0, thr});
			leak_w <= lk;
			repeat (4) @(posedge pclk);
			chk("gf", ground_fault, (9'(lk) + 9'(thr)) > 9'h0FF);
			chk("gate", gate_enable, !((9'(lk) + 9'(thr)) > 9'h0FF));
			leak_w <= 8'h00;
			key(K_GF_CLR);
		end
		// ----------------------------------------
		// overload and thermal memory
		// ----------------------------------------
		apb(1'b1, ADR_OL_SET, 32'h2);
		cur_w <= 8'h02;
		repeat (100) @(posedge pclk);
		chk("ol_eq", overload_fault, 1'b0);
		cur_w <= 8'hFF;
		waitv("ol", overload_fault, 1'b1, 100);
		waitv("ol_stop", motor_run, 1'b0, 4);
		apb(1'b0, ADR_THERM, 32'h0);
		chk("heat", q != 32'h0, 1'b1);
		apb(1'b0, ADR_COOL, 32'h0);
		chk("cool", q > 32'(COOL_TICKS) - 32'd10 && q <= 32'(COOL_TICKS), 1'b1);
		apb(1'b1, ADR_THERM, 32'h10000);
		apb(1'b0, ADR_THERM, 32'h0);
		chk("retain", q >= 32'hFFF0 && q <= 32'h10000, 1'b1);
		// ----------------------------------------
		// power-up with restarts allowed
		// ----------------------------------------
		cur_w <= 8'h00;
		want <= 4'h3;
		strap <= 1'b1;
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADR_STATUS, 32'h0);
		chk("mode", q[3:0], M_AUTO);
		waitv("auto", motor_run, 1'b1, 40);
		apb(1'b0, ADR_CTRL, 32'h0);
		chk("restart", q[0], 1'b1);
		// restore, then step the wizard choice and accept it
		key(K_RESTORE);
		key(K_UP);
		key(K_UP);
		key(K_DOWN);
		apb(1'b0, ADR_STATUS, 32'h0);
		chk("wiz_sel", q[22:19], 4'h3);
		key(K_ENTER);
		waitv("wiz_done", wizard_active, 1'b0, 4);
		apb(1'b0, ADR_CTRL, 32'h0);
		chk("restored", q, 32'h10);
		summarize();
	end
endmodule
